// *** hdl/temp_mon_pkg.sv ***
// Constants, register map and types shared by the temperature monitor files
package temp_mon_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_LOCAL   = 8'h00;
  localparam logic [7:0] ADDR_R1_HI   = 8'h01;
  localparam logic [7:0] ADDR_STATUS1 = 8'h02;
  localparam logic [7:0] ADDR_CONFIG  = 8'h03;
  localparam logic [7:0] ADDR_RATE    = 8'h04;
  localparam logic [7:0] ADDR_R1_LO   = 8'h10;
  localparam logic [7:0] ADDR_STATUS2 = 8'h23;
  localparam logic [7:0] ADDR_MASK1   = 8'h24;
  localparam logic [7:0] ADDR_MASK2   = 8'h25;
  localparam logic [7:0] ADDR_R2_HI   = 8'h30;
  localparam logic [7:0] ADDR_R2_LO   = 8'h33;
  localparam logic [3:0] LIMIT_PAGE   = 4'h4;

  // ------------------------------------------------------------------
  // Configuration bits and reset values
  // ------------------------------------------------------------------
  localparam int CFG_TIMEOUT_EN = 0;
  localparam int CFG_EXT_RANGE  = 2;
  localparam int CFG_R2_SEL     = 3;
  localparam int CFG_SECOND_OVERTEMP_OUT_N     = 5;
  localparam int CFG_STANDBY    = 6;
  localparam int CFG_ALERT_MASK = 7;

  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] RATE_RST   = 8'h07;
  localparam logic [7:0] RATE_MAX   = 8'h0A;
  localparam logic [7:0] RATE_NOAVG = 8'h08;
  localparam logic [7:0] HIGH_RST   = 8'h55;
  localparam logic [7:0] LOW_RST    = 8'h00;
  localparam logic [7:0] OVERTEMP_OUT_N_RST  = 8'h55;

  // Status layout: high/low pairs per channel, then open flags in status 1; overtemp per channel, then timeout in status 2
  localparam int ST2_TIMEOUT = 3;
  localparam int ST1_OPEN    = 5;

  // ------------------------------------------------------------------
  // Data format
  // ------------------------------------------------------------------
  localparam int                AVG_LOG2   = 4;
  localparam logic signed [10:0] EXT_OFFSET = 11'sh040;
  localparam logic signed [10:0] BIN_MAX    = 11'sh07F;
  localparam logic signed [10:0] EXT_MAX    = 11'sh0FF;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam longint CLK_HZ          = 200_000_000;
  localparam longint TIMEOUT_MS      = 25;
  localparam longint TIMEOUT_CYC     = (CLK_HZ * TIMEOUT_MS + 999) / 1000;
  localparam longint BASE_PERIOD_MS  = 16000;
  localparam longint BASE_PERIOD_CYC = CLK_HZ * BASE_PERIOD_MS / 1000;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  localparam int NUM_CH = 3;
  typedef enum logic [1:0] {
    CH_LOCAL = 2'h0,
    CH_R1    = 2'h1,
    CH_R2    = 2'h2
  } chan_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_REQ   = 5'h02,
    ST_WAIT  = 5'h04,
    ST_STORE = 5'h08,
    ST_PAUSE = 5'h10
  } conv_state_t;

endpackage

// *** hdl/sync3.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sync3 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit moves only once stages two and three agree
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        q[i] <= 1'b0;
      end else if (s2_q[i] == s3_q[i]) begin
        q[i] <= s3_q[i];
      end
    end
  end

endmodule

// *** hdl/sample_avg.sv ***
// Accumulator that averages a power-of-two number of samples
`timescale 1ns/1ps
module sample_avg #(
  parameter int SW   = 12,
  parameter int LOG2 = 4
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // Control
  input  wire logic                 clear,
  input  wire logic                 add,
  input  wire logic                 avg_on,
  // Data
  input  wire logic signed [SW-1:0] sample,
  output logic signed      [SW-1:0] avg
);

  logic signed [SW+LOG2-1:0] acc_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_q <= '0;
    end else if (clear) begin
      acc_q <= '0;
    end else if (add) begin
      acc_q <= acc_q + (SW+LOG2)'(sample);
    end
  end

  // Single samples pass unshifted when averaging is off
  always_comb begin
    if (avg_on) begin
      avg = SW'(acc_q >>> LOG2);
    end else begin
      avg = acc_q[SW-1:0];
    end
  end

endmodule

// *** hdl/temp_monitor.sv ***
// Temperature monitor: conversion sequencer, limits, alarms, registers, link timeout
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module temp_monitor
  import temp_mon_pkg::*;
#(
  parameter logic [31:0] BASE_PERIOD = 32'(BASE_PERIOD_CYC),
  parameter logic [31:0] TIMEOUT     = 32'(TIMEOUT_CYC)
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  // Converter front end
  output logic                    adc_start,
  output logic      [1:0]         adc_channel,
  input  wire logic signed [11:0] adc_sample,
  input  wire logic               adc_valid,
  input  wire logic               adc_open,
  // Serial link pins
  input  wire logic               serial_clk_pin,
  input  wire logic               serial_data_pin,
  output logic                    link_release,
  // Alarms
  output logic                    overtemp_out_n,
  output logic                    second_overtemp_out_n,
  output logic                    irq
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic limit_hit(input logic [7:0] a);
    return (a[7:4] == LIMIT_PAGE) && (a[3:2] != 2'h3) && (a[1:0] != 2'h3);
  endfunction

  // Quarter-degree sample to high byte, clamped to the selected scale
  function automatic logic [7:0] scale_hi(input logic signed [11:0] s, input logic ext);
    logic signed [10:0] v;
    v = {s[11], s[11:2]};
    if (ext) begin
      v = v + EXT_OFFSET;
    end
    if (v < 11'sh000) begin
      return 8'h00;
    end else if (v > (ext ? EXT_MAX : BIN_MAX)) begin
      return (ext ? EXT_MAX[7:0] : BIN_MAX[7:0]);
    end
    return v[7:0];
  endfunction

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [7:0]  cfg_q;
  logic [7:0]  rate_q;
  logic [7:0]  status1_q;
  logic [7:0]  status2_q;
  logic [7:0]  mask1_q;
  logic [7:0]  mask2_q;
  logic [7:0]  limit_q [NUM_CH][3];
  logic [7:0]  temp_hi_q [NUM_CH];
  logic [7:0]  temp_lo_q [NUM_CH];
  logic [7:0]  rd_val;
  logic [7:0]  set1;
  logic [7:0]  set2;
  logic        wr_status1;
  logic        wr_status2;

  conv_state_t state_q;
  chan_t       ch_q;
  logic [3:0]  samp_cnt_q;
  logic [31:0] seq_cnt_q;
  logic [NUM_CH-1:0] ot_live_q;
  logic        open_seen_q;
  logic        avg_on;
  logic        ext;
  logic [3:0]  samp_last;
  logic [31:0] period;
  logic signed [11:0] avg;
  logic [7:0]  res_hi;
  logic        hi_cmp;
  logic        lo_cmp;
  logic        ot_cmp;

  assign ext       = cfg_q[CFG_EXT_RANGE];
  assign avg_on    = (rate_q < RATE_NOAVG);
  assign samp_last = avg_on ? 4'hF : 4'h0;
  assign period    = BASE_PERIOD >> rate_q[3:0];
  assign res_hi    = scale_hi(avg, ext);
  assign hi_cmp    = res_hi > limit_q[ch_q][0];
  assign lo_cmp    = res_hi < limit_q[ch_q][1];
  assign ot_cmp    = res_hi > limit_q[ch_q][2];

  // ------------------------------------------------------------------
  // Averaging accumulator
  // ------------------------------------------------------------------
  sample_avg #(
    .SW   (12),
    .LOG2 (AVG_LOG2)
  ) u_avg (
    .clk     (clk),
    .reset_n (reset_n),
    .clear   ((state_q == ST_STORE) || (state_q == ST_IDLE)),
    .add     ((state_q == ST_WAIT) && adc_valid),
    .avg_on  (avg_on),
    .sample  (adc_sample),
    .avg     (avg)
  );

  // ------------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= ST_IDLE;
      ch_q       <= CH_LOCAL;
      samp_cnt_q <= 4'h0;
      seq_cnt_q  <= 32'h0;
    end else begin
      seq_cnt_q <= seq_cnt_q + 32'h1;
      case (state_q)
        ST_IDLE: begin
          ch_q       <= CH_LOCAL;
          samp_cnt_q <= 4'h0;
          seq_cnt_q  <= 32'h0;
          if (!cfg_q[CFG_STANDBY]) begin
            state_q <= ST_REQ;
          end
        end
        ST_REQ: begin
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (adc_valid) begin
            if (samp_cnt_q == samp_last) begin
              state_q <= ST_STORE;
            end else begin
              samp_cnt_q <= samp_cnt_q + 4'h1;
              state_q    <= ST_REQ;
            end
          end
        end
        ST_STORE: begin
          samp_cnt_q <= 4'h0;
          if (ch_q == CH_R2) begin
            state_q <= ST_PAUSE;
          end else begin
            ch_q    <= chan_t'(ch_q + 2'h1);
            state_q <= ST_REQ;
          end
        end
        ST_PAUSE: begin
          if (seq_cnt_q >= period - 32'h1) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Front-end request; one pulse per measurement
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      adc_start   <= 1'b0;
      adc_channel <= 2'h0;
    end else begin
      adc_start   <= (state_q == ST_REQ);
      adc_channel <= ch_q;
    end
  end

  // Open diode is remembered across the samples of one channel
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      open_seen_q <= 1'b0;
    end else if (state_q == ST_STORE || state_q == ST_IDLE) begin
      open_seen_q <= 1'b0;
    end else if (state_q == ST_WAIT && adc_valid && adc_open) begin
      open_seen_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Result storage and live overtemp
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int c = 0; c < NUM_CH; c++) begin
        temp_hi_q[c] <= 8'h00;
        temp_lo_q[c] <= 8'h00;
      end
      ot_live_q <= '0;
    end else if (state_q == ST_STORE) begin
      temp_hi_q[ch_q] <= res_hi;
      temp_lo_q[ch_q] <= {avg[1:0], 6'h00};
      ot_live_q[ch_q] <= ot_cmp;
    end
  end

  // ------------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------------
  always_comb begin
    set1 = 8'h00;
    set2 = 8'h00;
    if (state_q == ST_STORE) begin
      set1[{ch_q, 1'b0}] = hi_cmp;
      set1[{ch_q, 1'b1}] = lo_cmp;
      set2[ch_q]         = ot_cmp;
      if (ch_q != CH_LOCAL) begin
        set1[ST1_OPEN + int'(ch_q)] = open_seen_q;
      end
    end
    set2[ST2_TIMEOUT] = link_release;
  end

  assign wr_status1 = reg_wr && (reg_addr == ADDR_STATUS1);
  assign wr_status2 = reg_wr && (reg_addr == ADDR_STATUS2);

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status1_q <= 8'h00;
      status2_q <= 8'h00;
    end else begin
      status1_q <= (status1_q & ~(wr_status1 ? reg_wdata : 8'h00)) | set1;
      status2_q <= (status2_q & ~(wr_status2 ? reg_wdata : 8'h00)) | set2;
    end
  end

  // ------------------------------------------------------------------
  // Host-writable registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q   <= CONFIG_RST;
      rate_q  <= RATE_RST;
      mask1_q <= 8'h00;
      mask2_q <= 8'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_CONFIG: cfg_q   <= reg_wdata;
        ADDR_MASK1:  mask1_q <= reg_wdata;
        ADDR_MASK2:  mask2_q <= reg_wdata;
        ADDR_RATE: begin
          rate_q <= (reg_wdata > RATE_MAX) ? RATE_MAX : reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int c = 0; c < NUM_CH; c++) begin
        limit_q[c][0] <= HIGH_RST;
        limit_q[c][1] <= LOW_RST;
        limit_q[c][2] <= OVERTEMP_OUT_N_RST;
      end
    end else if (reg_wr && limit_hit(reg_addr)) begin
      limit_q[reg_addr[3:2]][reg_addr[1:0]] <= reg_wdata;
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  always_comb begin
    rd_val = 8'h00;
    if (limit_hit(reg_addr)) begin
      rd_val = limit_q[reg_addr[3:2]][reg_addr[1:0]];
    end else begin
      case (reg_addr)
        ADDR_LOCAL:   rd_val = temp_hi_q[CH_LOCAL];
        ADDR_R1_HI:   rd_val = temp_hi_q[cfg_q[CFG_R2_SEL] ? CH_R2 : CH_R1];
        ADDR_R1_LO:   rd_val = temp_lo_q[cfg_q[CFG_R2_SEL] ? CH_R2 : CH_R1];
        ADDR_R2_HI:   rd_val = temp_hi_q[CH_R2];
        ADDR_R2_LO:   rd_val = temp_lo_q[CH_R2];
        ADDR_STATUS1: rd_val = status1_q;
        ADDR_STATUS2: rd_val = status2_q;
        ADDR_CONFIG:  rd_val = cfg_q;
        ADDR_RATE:    rd_val = rate_q;
        ADDR_MASK1:   rd_val = mask1_q;
        ADDR_MASK2:   rd_val = mask2_q;
        default:      rd_val = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // Alarm pins and interrupt
  // ------------------------------------------------------------------
  // Overtemp follows the latest results, not the sticky status
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      overtemp_out_n        <= 1'b1;
      second_overtemp_out_n <= 1'b1;
      irq                   <= 1'b0;
    end else begin
      overtemp_out_n <= ~(|ot_live_q);
      if (cfg_q[CFG_SECOND_OVERTEMP_OUT_N]) begin
        second_overtemp_out_n <= ~(|ot_live_q);
      end else begin
        second_overtemp_out_n <= ~((|status1_q) & ~cfg_q[CFG_ALERT_MASK]);
      end
      irq <= |((status1_q & mask1_q) | (status2_q & mask2_q));
    end
  end

  // ------------------------------------------------------------------
  // Serial link stall timeout
  // ------------------------------------------------------------------
  logic [1:0]  link_s;
  logic [1:0]  link_prev_q;
  logic        busy_q;
  logic [31:0] stall_cnt_q;

  sync3 #(
    .WIDTH (2)
  ) u_link_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       ({serial_clk_pin, serial_data_pin}),
    .q       (link_s)
  );

  // Index 1 is clock, 0 is data; start and stop move data with clock high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link_prev_q  <= 2'h3;
      busy_q       <= 1'b0;
      stall_cnt_q  <= 32'h0;
      link_release <= 1'b0;
    end else begin
      link_prev_q  <= link_s;
      link_release <= 1'b0;
      if (link_s[1] && link_prev_q[1] && link_prev_q[0] && !link_s[0]) begin
        busy_q <= 1'b1;
      end else if (link_s[1] && link_prev_q[1] && !link_prev_q[0] && link_s[0]) begin
        busy_q <= 1'b0;
      end
      if (!cfg_q[CFG_TIMEOUT_EN] || !busy_q || link_s[1]) begin
        stall_cnt_q <= 32'h0;
      end else if (stall_cnt_q >= TIMEOUT - 32'h1) begin
        stall_cnt_q  <= 32'h0;
        busy_q       <= 1'b0;
        link_release <= 1'b1;
      end else begin
        stall_cnt_q <= stall_cnt_q + 32'h1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_seq_advance: assert property ((state_q == ST_STORE) && (ch_q != CH_R2) |=>
    (state_q == ST_REQ) && (ch_q == chan_t'($past(ch_q) + 2'h1)))
    else $error("channel sequence did not advance");

  a_store_value: assert property ((state_q == ST_STORE) |=>
    temp_hi_q[$past(ch_q)] == $past(res_hi))
    else $error("result not stored in its channel register");

  a_high_flag: assert property ((state_q == ST_STORE) && hi_cmp |=>
    status1_q[$past({ch_q, 1'b0})])
    else $error("high limit flag not set");

  a_overtemp_out_n_pin: assert property ((state_q == ST_STORE) && ot_cmp |=> ##1
    !overtemp_out_n)
    else $error("overtemp pin not asserted");

  a_alert_pin: assert property ((|status1_q) && !cfg_q[CFG_ALERT_MASK]
    && !cfg_q[CFG_SECOND_OVERTEMP_OUT_N] |=> !second_overtemp_out_n)
    else $error("alarm pin not asserted");

  a_alert_mask: assert property (!cfg_q[CFG_SECOND_OVERTEMP_OUT_N] && cfg_q[CFG_ALERT_MASK]
    |=> second_overtemp_out_n)
    else $error("masked alarm pin asserted");

  a_second_overtemp_out_n_mode: assert property ($past(cfg_q[CFG_SECOND_OVERTEMP_OUT_N]) |->
    second_overtemp_out_n == overtemp_out_n)
    else $error("second overtemp output differs from overtemp");

  a_read_back: assert property (reg_rd && (reg_addr == ADDR_CONFIG) |=>
    reg_rdata == $past(cfg_q))
    else $error("config read back wrong");

  a_standby_hold: assert property (cfg_q[CFG_STANDBY] && (state_q == ST_IDLE)
    |=> ##1 !adc_start)
    else $error("conversion started in standby");

  a_avg_count: assert property ((state_q == ST_STORE) |->
    samp_cnt_q == $past(samp_last))
    else $error("wrong number of samples averaged");

  a_timeout_off: assert property (!$past(cfg_q[CFG_TIMEOUT_EN]) |->
    !link_release)
    else $error("link released while timeout disabled");

endmodule

// *** verif/adc_front_model.sv ***
// Converter front end model answering measurement requests
`timescale 1ns/1ps
module adc_front_model (
  // Clock
  input  wire logic              clk,
  // Requests
  input  wire logic              adc_start,
  input  wire logic [1:0]        adc_channel,
  // Answers
  output logic signed [11:0]     adc_sample,
  output logic                   adc_valid,
  output logic                   adc_open
);
  logic               [2:0]  wait_q;
  logic signed        [11:0] temp_q [3];

  initial begin
    temp_q     = '{12'sh190, 12'sh028, 12'sh0C8};
    wait_q     = 3'h0;
    adc_valid  = 1'b0;
    adc_open   = 1'b0;
    adc_sample = 12'sh000;
  end

  always @(posedge clk) begin
    adc_valid  <= 1'b0;
    // Sample bus is not held outside valid
    adc_sample <= ~adc_sample;
    if (adc_start)
      wait_q <= 3'h3;
    else if (wait_q != 3'h0)
      wait_q <= wait_q - 3'h1;
    if (wait_q == 3'h1) begin
      adc_valid  <= 1'b1;
      adc_sample <= temp_q[adc_channel];
    end
  end
endmodule

// *** verif/temp_monitor_tb_top.sv ***
// Testbench for the temperature monitor
`timescale 1ns/1ps
module temp_monitor_tb_top;
  import temp_mon_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
  logic adc_start, adc_valid, adc_open, link_release, ot_n, ot2_n, irq;
  logic [1:0] adc_channel;
  logic signed [11:0] adc_sample;
  logic scl = 1'b1, sda = 1'b1;
  int err_total = 0, samples_checked = 0, n;

  always #2.5 clk = ~clk;

  temp_monitor #(.BASE_PERIOD(32'd4096), .TIMEOUT(32'd200)) u_dut (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_start(adc_start),
    .adc_channel(adc_channel), .adc_sample(adc_sample), .adc_valid(adc_valid),
    .adc_open(adc_open), .serial_clk_pin(scl), .serial_data_pin(sda),
    .link_release(link_release), .overtemp_out_n(ot_n),
    .second_overtemp_out_n(ot2_n), .irq(irq));

  adc_front_model u_adc (.clk(clk), .adc_start(adc_start), .adc_channel(adc_channel),
    .adc_sample(adc_sample), .adc_valid(adc_valid), .adc_open(adc_open));

  // ------------------------------------------------------------------
  // Bus tasks and checks
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 chk("register", exp, reg_rdata);
  endtask

  // Bounded wait for a request on one channel
  task automatic wait_start(input logic [1:0] ch);
    n = 0;
    while (!(adc_start === 1'b1 && adc_channel === ch) && n < 9000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 9000) give_verdict(1);
    @(posedge clk);
  endtask

  task automatic give_verdict(input bit hung);
    if (hung)
      err_total++;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rd(ADDR_CONFIG, CONFIG_RST);
    rd(ADDR_RATE, RATE_RST);
    rd(8'h40, HIGH_RST);
    rd(8'h42, OVERTEMP_OUT_N_RST);
    rd(8'hFF, 8'h00);
    wait_start(2'h1);
    wait_start(2'h2);
    wait_start(2'h0);
    wr(ADDR_RATE, 8'h0C);
    rd(ADDR_RATE, RATE_MAX);
    wr(ADDR_RATE, RATE_NOAVG);
    wait_start(2'h0);
    wait_start(2'h0);
    rd(ADDR_LOCAL, 8'h64);
    rd(ADDR_R2_HI, 8'h32);
    rd(ADDR_STATUS1, 8'h01);
    wr(8'h45, 8'h0B);
    wait_start(2'h1);
    wait_start(2'h2);
    rd(ADDR_STATUS1, 8'h09);
    rd(ADDR_STATUS2, 8'h01);
    chk("overtemp pin", 8'h00, {7'h0, ot_n});
    chk("alarm pin", 8'h00, {7'h0, ot2_n});
    wr(ADDR_CONFIG, 8'h88);
    repeat (3) @(posedge clk);
    chk("masked alarm", 8'h01, {7'h0, ot2_n});
    rd(ADDR_R1_HI, 8'h32);
    wr(ADDR_CONFIG, 8'hA8);
    repeat (3) @(posedge clk);
    chk("second overtemp", 8'h00, {7'h0, ot2_n});
    chk("irq idle", 8'h00, {7'h0, irq});
    wr(ADDR_MASK2, 8'h01);
    repeat (3) @(posedge clk);
    chk("irq", 8'h01, {7'h0, irq});
    wr(ADDR_CONFIG, 8'h05);
    wait_start(2'h0);
    wait_start(2'h1);
    rd(ADDR_LOCAL, 8'hA4);
    @(posedge clk);
    sda <= 1'b0;
    repeat (8) @(posedge clk);
    scl <= 1'b0;
    n = 0;
    while (link_release !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("link release", 8'h01, {7'h0, link_release});
    repeat (2) @(posedge clk);
    rd(ADDR_STATUS2, 8'h0D);
    wr(ADDR_CONFIG, 8'h40);
    repeat (100) @(posedge clk);
    n = 0;
    repeat (300) begin
      @(posedge clk);
      if (adc_start !== 1'b0)
        n++;
    end
    chk("standby starts", 8'h00, 8'(n));
    give_verdict(0);
  end
endmodule
